// ==== rtl/prefetch_cache_pkg.sv ====
// Package for the upstream read pre-fetch and completion cache control block.
// Assumes a 32-bit APB slave with word-aligned registers at four times the index.
package prefetch_cache_pkg;

  // Register indices and byte addresses
  localparam logic [9:0] IDX_PREFETCH_LIMITS = 10'h0e8;
  localparam logic [9:0] IDX_IDLE_XFER_LIMIT = 10'h0ea;
  localparam logic [9:0] IDX_IDLE_LOWER = 10'h0ec;
  localparam logic [9:0] IDX_IDLE_UPPER = 10'h0ee;
  localparam logic [9:0] IDX_AGENT_STATUS = 10'h0f0;
  localparam logic [11:0] ADDR_PREFETCH_LIMITS = {IDX_PREFETCH_LIMITS, 2'b00};
  localparam logic [11:0] ADDR_IDLE_XFER_LIMIT = {IDX_IDLE_XFER_LIMIT, 2'b00};
  localparam logic [11:0] ADDR_IDLE_LOWER = {IDX_IDLE_LOWER, 2'b00};
  localparam logic [11:0] ADDR_IDLE_UPPER = {IDX_IDLE_UPPER, 2'b00};
  localparam logic [11:0] ADDR_AGENT_STATUS = {IDX_AGENT_STATUS, 2'b00};

  // Reset values
  localparam logic [15:0] RST_PREFETCH_LIMITS = 16'h0443;
  localparam logic [15:0] RST_IDLE_XFER_LIMIT = 16'h0008;
  localparam logic [15:0] RST_IDLE_LOWER = 16'h007f;
  localparam logic [15:0] RST_IDLE_UPPER = 16'h01c0;

  // Writable bit masks; everything else reads as zero
  localparam logic [15:0] WMASK_PREFETCH_LIMITS = 16'h0fcf;
  localparam logic [15:0] WMASK_IDLE_XFER_LIMIT = 16'h00ff;
  localparam logic [15:0] WMASK_IDLE_BOUND = 16'h0fff;

  // Field positions in the pre-fetch limits register
  localparam int BURST_HI = 11;
  localparam int BURST_LO = 8;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int LEN_HI = 3;
  localparam int LEN_LO = 0;

  // Burst count limit codes
  localparam logic [3:0] BURST_OFF = 4'h0;
  localparam logic [3:0] BURST_ONE = 4'h1;
  localparam logic [3:0] BURST_MIN_PREFETCH = 4'h2;

  // Byte length limit
  localparam logic [3:0] LEN_MAX_CODE = 4'h7;
  localparam logic [13:0] LEN_BASE_BYTES = 14'h0040;

  // Completion retention modes
  typedef enum logic [1:0] {
    RETAIN_NONE = 2'b00,
    RETAIN_LIGHT = 2'b01,
    RETAIN_FULL = 2'b10,
    RETAIN_RSVD = 2'b11
  } retain_mode_e;

  // Events from the PCI-side read engine, one-cycle pulses except ended_by_retry
  typedef struct packed {
    logic read_start;
    logic completion_fill;
    logic data_return;
    logic xfer_end;
    logic ended_by_retry;
    logic cycle_start;
    logic read_hit;
  } pci_event_s;

endpackage : prefetch_cache_pkg

// ==== rtl/idle_discard_timer.sv ====
// Idle timers that decide when cached completion data is thrown away.
// Assumes single-cycle event pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module idle_discard_timer #(
  parameter int CLK_W = 12,
  parameter int START_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_clear,
  // Cache activity
  input wire logic active,
  input wire logic cycle_start,
  input wire logic read_hit,
  // Limits
  input wire logic [START_W-1:0] start_limit,
  input wire logic [CLK_W-1:0] lower_bound,
  input wire logic [CLK_W-1:0] upper_bound,
  // Decision
  output logic discard_o
);

  logic [CLK_W-1:0] idle_clks;
  logic [START_W-1:0] idle_starts;
  wire restart = soft_clear || !active || read_hit;
  wire clk_sat = &idle_clks;
  wire start_sat = &idle_starts;
  wire upper_hit = idle_clks >= upper_bound;
  wire lower_hit = idle_clks >= lower_bound;
  wire start_hit = idle_starts >= start_limit;

  // Idle counters, restarted on a hit or when nothing is cached
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_clks <= '0;
      idle_starts <= '0;
    end else if (restart) begin
      idle_clks <= '0;
      idle_starts <= '0;
    end else begin
      if (!clk_sat) idle_clks <= idle_clks + 1'b1;
      if (cycle_start && !start_sat) idle_starts <= idle_starts + 1'b1;
    end
  end

  // Upper bound alone, or miss check gated by the lower bound
  assign discard_o = active && (upper_hit || (start_hit && lower_hit));

  AST_HIT_RESTARTS: assert property (@(posedge clk) disable iff (!rst_n)
    read_hit && !soft_clear |=> idle_clks == '0 && idle_starts == '0)
    else $error("idle counters not restarted by hit");
  AST_UPPER_DISCARDS: assert property (@(posedge clk) disable iff (!rst_n)
    active && idle_clks >= upper_bound |-> discard_o)
    else $error("upper bound reached without discard");
  AST_LOWER_GATES: assert property (@(posedge clk) disable iff (!rst_n)
    idle_clks < lower_bound && idle_clks < upper_bound |-> !discard_o)
    else $error("discard before lower bound");
  AST_MISS_NEEDS_STARTS: assert property (@(posedge clk) disable iff (!rst_n)
    discard_o && idle_clks < upper_bound |-> idle_starts >= start_limit)
    else $error("discard without enough cycle starts");

endmodule : idle_discard_timer
`default_nettype wire

// ==== rtl/upstream_read_prefetch_cache.sv ====
// Control of the upstream read pre-fetch agent and its completion cache.
// Assumes an APB master on REF_CLK_I and a PCI-side read engine on the same clock.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module upstream_read_prefetch_cache
  import prefetch_cache_pkg::*;
#(
  parameter int CLK_W = 12,
  parameter int START_W = 8
) (
  // Clock and resets
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic GLOBAL_RESET_INPUT_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // PCI-side events
  input wire pci_event_s PCI_EVENT_I,
  // Pre-fetch request handshake
  output logic PREFETCH_REQ_O,
  input wire logic PREFETCH_ACK_I,
  output logic [13:0] THREAD_BYTE_LIMIT_O,
  output logic SINGLE_BUFFER_O,
  // Cache state
  output logic CACHE_VALID_O,
  output logic DISCARD_O
);

  if (CLK_W != 12 || START_W != 8) begin : g_check
    $error("timer widths must match the 12-bit and 8-bit register fields");
  end

  typedef enum logic {PF_IDLE, PF_ISSUE} pf_state_e;

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [1:0] global_reset_input_pipe;
  logic [15:0] limits_reg;
  logic [15:0] xfer_reg;
  logic [15:0] lower_reg;
  logic [15:0] upper_reg;
  pf_state_e state;
  pf_state_e next_state;
  logic [3:0] issued;
  logic [3:0] next_issued;
  logic cache_valid;
  logic next_cache_valid;
  logic timer_discard;

  // Reset release through two flops
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) rst_pipe <= 2'b00;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // Global reset pin synchroniser; only the second flop is used
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) global_reset_input_pipe <= 2'b11;
    else global_reset_input_pipe <= {global_reset_input_pipe[0], GLOBAL_RESET_INPUT_N_I};
  end
  wire global_reset_input = !global_reset_input_pipe[1];

  // APB decode
  wire access = PSEL_I && PENABLE_I;
  wire hit_limits = PADDR_I == ADDR_PREFETCH_LIMITS;
  wire hit_xfer = PADDR_I == ADDR_IDLE_XFER_LIMIT;
  wire hit_lower = PADDR_I == ADDR_IDLE_LOWER;
  wire hit_upper = PADDR_I == ADDR_IDLE_UPPER;
  wire hit_status = PADDR_I == ADDR_AGENT_STATUS;
  wire mapped = hit_limits || hit_xfer || hit_lower || hit_upper || hit_status;
  wire wr = access && PWRITE_I;
  wire [15:0] wdata = PWDATA_I[15:0];

  // Zero-wait slave, error on unmapped addresses or status write
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access && (!mapped || (PWRITE_I && hit_status));

  // Configuration registers, loaded with their reset values by either of the resets
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      limits_reg <= RST_PREFETCH_LIMITS;
      xfer_reg <= RST_IDLE_XFER_LIMIT;
      lower_reg <= RST_IDLE_LOWER;
      upper_reg <= RST_IDLE_UPPER;
    end else if (global_reset_input) begin
      limits_reg <= RST_PREFETCH_LIMITS;
      xfer_reg <= RST_IDLE_XFER_LIMIT;
      lower_reg <= RST_IDLE_LOWER;
      upper_reg <= RST_IDLE_UPPER;
    end else if (wr) begin
      if (hit_limits) limits_reg <= wdata & WMASK_PREFETCH_LIMITS;
      if (hit_xfer) xfer_reg <= wdata & WMASK_IDLE_XFER_LIMIT;
      if (hit_lower) lower_reg <= wdata & WMASK_IDLE_BOUND;
      if (hit_upper) upper_reg <= wdata & WMASK_IDLE_BOUND;
    end
  end

  // Field extraction
  wire [3:0] burst_limit = limits_reg[BURST_HI:BURST_LO];
  wire [1:0] mode_bits = limits_reg[MODE_HI:MODE_LO];
  wire [3:0] len_code = limits_reg[LEN_HI:LEN_LO];
  wire retain_mode_e mode = retain_mode_e'(mode_bits);
  wire agent_on = burst_limit != BURST_OFF;
  wire mode_prefetch = mode == RETAIN_LIGHT || mode == RETAIN_FULL;
  wire prefetch_allowed = burst_limit >= BURST_MIN_PREFETCH && mode_prefetch;
  wire [3:0] prefetch_target = burst_limit - 4'h1;

  // Status word: cache and agent state
  wire [15:0] status_word = {8'h00, issued, 2'b00, state == PF_ISSUE, cache_valid};

  // Read data; reserved bits already zero in storage
  always_comb begin
    PRDATA_O = 32'h0000_0000;
    if (access && !PWRITE_I) begin
      unique case (1'b1)
        hit_limits: PRDATA_O = {16'h0000, limits_reg};
        hit_xfer: PRDATA_O = {16'h0000, xfer_reg};
        hit_lower: PRDATA_O = {16'h0000, lower_reg};
        hit_upper: PRDATA_O = {16'h0000, upper_reg};
        hit_status: PRDATA_O = {16'h0000, status_word};
        default: PRDATA_O = 32'h0000_0000;
      endcase
    end
  end

  // Byte limit per thread; reserved codes fall back to the base size
  logic [13:0] byte_limit;
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    // Reset value already matches the default length code
    if (!rst_n) byte_limit <= LEN_BASE_BYTES << RST_PREFETCH_LIMITS[LEN_HI:LEN_LO];
    else if (len_code > LEN_MAX_CODE) byte_limit <= LEN_BASE_BYTES;
    else byte_limit <= LEN_BASE_BYTES << len_code[2:0];
  end
  assign THREAD_BYTE_LIMIT_O = byte_limit;

  // Single buffer indication for burst limit one
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) SINGLE_BUFFER_O <= 1'b0;
    else SINGLE_BUFFER_O <= burst_limit == BURST_ONE;
  end

  // Pre-fetch agent: issues further reads after a thread's initial read
  always_comb begin
    next_state = state;
    next_issued = issued;
    unique case (state)
      PF_IDLE: begin
        if (PCI_EVENT_I.read_start && prefetch_allowed) begin
          next_state = PF_ISSUE;
          next_issued = 4'h0;
        end
      end
      PF_ISSUE: begin
        if (!prefetch_allowed) begin
          next_state = PF_IDLE;
        end else if (PCI_EVENT_I.read_start) begin
          next_issued = 4'h0;
        end else if (issued >= prefetch_target) begin
          next_state = PF_IDLE;
        end else if (PREFETCH_ACK_I) begin
          next_issued = issued + 4'h1;
          if (issued + 4'h1 >= prefetch_target) next_state = PF_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= PF_IDLE;
      issued <= 4'h0;
    end else if (global_reset_input) begin
      state <= PF_IDLE;
      issued <= 4'h0;
    end else begin
      state <= next_state;
      issued <= next_issued;
    end
  end

  // Request only while the mode still allows it
  // A limit lowered mid-burst must not let the count run past it
  assign PREFETCH_REQ_O = state == PF_ISSUE && prefetch_allowed
                          && issued < prefetch_target;

  // Retention decision at the end of a transfer
  wire keep_on_end = agent_on && ((mode == RETAIN_LIGHT && PCI_EVENT_I.ended_by_retry)
                                  || mode == RETAIN_FULL);
  wire drop_on_return = PCI_EVENT_I.data_return && !mode_prefetch;
  wire drop_on_end = PCI_EVENT_I.xfer_end && !keep_on_end;
  wire discard_now = cache_valid && (drop_on_return || drop_on_end || timer_discard || global_reset_input);

  // Cache valid flag; a fill in the same cycle as a discard wins, except during a global reset
  always_comb begin
    next_cache_valid = cache_valid;
    if (discard_now) next_cache_valid = 1'b0;
    if (PCI_EVENT_I.completion_fill && !global_reset_input) next_cache_valid = 1'b1;
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cache_valid <= 1'b0;
      DISCARD_O <= 1'b0;
    end else begin
      cache_valid <= next_cache_valid;
      DISCARD_O <= discard_now;
    end
  end
  assign CACHE_VALID_O = cache_valid;

  // Idle timers
  idle_discard_timer #(
    .CLK_W(CLK_W),
    .START_W(START_W)
  ) u_timer (
    .clk(REF_CLK_I),
    .rst_n(rst_n),
    .soft_clear(global_reset_input),
    .active(cache_valid),
    .cycle_start(PCI_EVENT_I.cycle_start),
    .read_hit(PCI_EVENT_I.read_hit),
    .start_limit(xfer_reg[START_W-1:0]),
    .lower_bound(lower_reg[CLK_W-1:0]),
    .upper_bound(upper_reg[CLK_W-1:0]),
    .discard_o(timer_discard)
  );

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_full_end;
    mode == RETAIN_FULL && agent_on && cache_valid && PCI_EVENT_I.xfer_end;
  endsequence
  sequence s_no_other_drop;
    !timer_discard && !global_reset_input && !PCI_EVENT_I.data_return;
  endsequence

  AST_OFF_NO_REQ: assert property (burst_limit == BURST_OFF |-> !PREFETCH_REQ_O)
    else $error("pre-fetch request with agent disabled");
  AST_ONE_NO_REQ: assert property (burst_limit == BURST_ONE |-> !PREFETCH_REQ_O)
    else $error("pre-fetch request with single buffer limit");
  AST_BURST_BOUND: assert property (PREFETCH_REQ_O |-> issued < prefetch_target)
    else $error("more pre-fetch reads than burst limit allows");
  AST_NONE_DROPS: assert property (mode == RETAIN_NONE && cache_valid
    && PCI_EVENT_I.data_return && !PCI_EVENT_I.completion_fill |=> !cache_valid)
    else $error("mode 00 kept data after return");
  AST_LIGHT_MASTER_END: assert property (mode == RETAIN_LIGHT && cache_valid
    && PCI_EVENT_I.xfer_end && !PCI_EVENT_I.ended_by_retry
    && !PCI_EVENT_I.completion_fill |=> !cache_valid && DISCARD_O ##1 !DISCARD_O)
    else $error("mode 01 kept data after master end");
  AST_FULL_KEEPS: assert property (s_full_end and s_no_other_drop |=> cache_valid)
    else $error("mode 10 dropped data at transfer end");
  AST_LEN_DECODE: assert property (len_code <= LEN_MAX_CODE
    |=> THREAD_BYTE_LIMIT_O == (LEN_BASE_BYTES << $past(len_code[2:0])))
    else $error("byte limit does not follow length code");
  AST_LIMITS_RSVD: assert property (access && !PWRITE_I && hit_limits
    |-> PRDATA_O[5:4] == 2'b00 && PRDATA_O[31:12] == '0)
    else $error("reserved limits bits read nonzero");
  AST_XFER_RSVD: assert property (access && !PWRITE_I && hit_xfer
    |-> PRDATA_O[31:8] == '0)
    else $error("transfer limit upper byte read nonzero");
  AST_GLOBAL_RESET_INPUT_DEFAULTS: assert property (global_reset_input |=> limits_reg == RST_PREFETCH_LIMITS
    && xfer_reg == RST_IDLE_XFER_LIMIT && lower_reg == RST_IDLE_LOWER
    && upper_reg == RST_IDLE_UPPER && !cache_valid)
    else $error("global reset did not restore defaults");

endmodule : upstream_read_prefetch_cache
`default_nettype wire

// ==== dv/pci_master_model.sv ====
// Behavioural PCI master: replays bench event pulses and accepts pre-fetch reads.
// Assumes the bench changes cmd_i right after rising edges of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pci_master_model
  import prefetch_cache_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench control
  input wire pci_event_s cmd_i,
  input wire logic [3:0] ack_wait_i,
  // Bridge side
  input wire logic prefetch_req_i,
  output var pci_event_s event_o,
  output logic prefetch_ack_o
);
  logic [3:0] wait_cnt;

  // Events pass one flop; a read is accepted after ack_wait_i cycles, never twice in a row
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_o <= '0;
      prefetch_ack_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      event_o <= cmd_i;
      if (prefetch_ack_o || !prefetch_req_i) begin
        prefetch_ack_o <= 1'b0;
        wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_wait_i) begin
        prefetch_ack_o <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : pci_master_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the pre-fetch and completion cache control block.
// Assumes zero-wait APB and a behavioural PCI master beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import prefetch_cache_pkg::*;
;
  localparam logic [6:0] E_RS = 7'h40;
  localparam logic [6:0] E_FILL = 7'h20;
  localparam logic [6:0] E_RET = 7'h10;
  localparam logic [6:0] E_END = 7'h08;
  localparam logic [6:0] E_RETRY = 7'h04;
  localparam logic [6:0] E_CS = 7'h02;
  localparam logic [6:0] E_HIT = 7'h01;
  localparam logic [15:0] BCFG [8] = '{16'h0043, 16'h0143, 16'h0243, 16'h0343, 16'h0443,
    16'h0f83, 16'h0303, 16'h03c3};
  localparam int BEXP [8] = '{0, 0, 1, 2, 3, 14, 0, 0};
  localparam logic [15:0] RCFG [5] = '{16'h0403, 16'h0443, 16'h0443, 16'h0483, 16'h0483};
  localparam logic [6:0] REV [5] = '{E_RET, E_END, E_END | E_RETRY, E_END, E_END | E_RETRY};
  localparam logic [31:0] REXP [5] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h1};
  logic clk, rst_n, global_reset_input_n, psel, penable, pwrite, pready, pslverr;
  logic req, ack, single_buf, valid, discard;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] byte_lim;
  logic [3:0] ack_wait;
  pci_event_s cmd, ev_bus;
  int mismatches, check_count, acks, discards;

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  upstream_read_prefetch_cache upstream_read_prefetch_cache_i (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .GLOBAL_RESET_INPUT_N_I(global_reset_input_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .PCI_EVENT_I(ev_bus), .PREFETCH_REQ_O(req), .PREFETCH_ACK_I(ack),
    .THREAD_BYTE_LIMIT_O(byte_lim), .SINGLE_BUFFER_O(single_buf),
    .CACHE_VALID_O(valid), .DISCARD_O(discard));

  pci_master_model pci_master_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .ack_wait_i(ack_wait),
    .prefetch_req_i(req), .event_o(ev_bus), .prefetch_ack_o(ack));

  // Count accepted pre-fetch reads and discard pulses
  always @(posedge clk) begin
    if (ack === 1'b1 && req === 1'b1) acks <= acks + 1;
    if (discard === 1'b1) discards <= discards + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the slave's answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
    chk($sformatf("wr_err %h", a), 32'h0, {31'h0, e});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk($sformatf("rd %h", a), exp, r);
  endtask : rd

  task automatic ev(input logic [6:0] v);
    @(posedge clk);
    cmd <= pci_event_s'(v);
    @(posedge clk);
    cmd <= '0;
  endtask : ev

  task automatic defaults();
    rd(ADDR_PREFETCH_LIMITS, 32'h0443);
    rd(ADDR_IDLE_XFER_LIMIT, 32'h0008);
    rd(ADDR_IDLE_LOWER, 32'h007f);
    rd(ADDR_IDLE_UPPER, 32'h01c0);
  endtask : defaults

  task automatic wait_disc(input int lo, input int hi);
    int n;
    n = 0;
    // Sample mid-cycle, where the registered pulse has settled
    while (discard !== 1'b1 && n <= hi) begin
      @(negedge clk);
      n++;
    end
    check_count++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("BAD discard_delay exp %0d..%0d got %0d", lo, hi, n);
    end
  endtask : wait_disc

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int i;
    int d0;
    rst_n = 1'b0;
    global_reset_input_n = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cmd = '0;
    ack_wait = 4'h0;
    acks = 0;
    discards = 0;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    defaults();
    rd(ADDR_AGENT_STATUS, 32'h0);
    wr(ADDR_PREFETCH_LIMITS, 32'hffffffff);
    rd(ADDR_PREFETCH_LIMITS, 32'h0fcf);
    wr(ADDR_IDLE_XFER_LIMIT, 32'hffffffff);
    rd(ADDR_IDLE_XFER_LIMIT, 32'h00ff);
    wr(ADDR_IDLE_LOWER, 32'hffffffff);
    rd(ADDR_IDLE_LOWER, 32'h0fff);
    wr(ADDR_IDLE_UPPER, 32'hffffffff);
    rd(ADDR_IDLE_UPPER, 32'h0fff);
    xfer(1'b0, 12'h004, 32'h0, r, e);
    chk("unmapped_rd", 32'h0, r);
    chk("unmapped_err", 32'h1, {31'h0, e});
    xfer(1'b1, ADDR_AGENT_STATUS, 32'hff, r, e);
    chk("status_wr_err", 32'h1, {31'h0, e});
    // Every valid length code, 0 to 7, and one reserved
    for (i = 0; i < 9; i++) begin
      wr(ADDR_PREFETCH_LIMITS, 32'h0480 | i);
      repeat (2) @(posedge clk);
      chk("byte_limit", (i < 8) ? (32'd64 << i) : 32'd64, {18'h0, byte_lim});
    end
    // Burst limits and modes; one slow partner case
    for (i = 0; i < 8; i++) begin
      ack_wait <= (i == 5) ? 4'h3 : 4'h0;
      wr(ADDR_PREFETCH_LIMITS, {16'h0, BCFG[i]});
      acks = 0;
      ev(E_RS);
      repeat (100) @(posedge clk);
      chk("prefetch_acks", BEXP[i], acks);
      if (BEXP[i] > 0) rd(ADDR_AGENT_STATUS, BEXP[i] << 4);
      chk("single_buf", {31'h0, BCFG[i][11:8] == 4'h1}, {31'h0, single_buf});
    end
    // Leftover data kept or dropped per retention mode
    for (i = 0; i < 5; i++) begin
      wr(ADDR_PREFETCH_LIMITS, {16'h0, RCFG[i]});
      ev(E_FILL);
      repeat (3) @(posedge clk);
      chk("valid_fill", 32'h1, {31'h0, valid});
      ev(REV[i]);
      repeat (3) @(posedge clk);
      chk("valid_after_end", REXP[i], {31'h0, valid});
      wr(ADDR_PREFETCH_LIMITS, 32'h0403);
      ev(E_RET);
      repeat (3) @(posedge clk);
    end
    // Idle clock bounds
    wr(ADDR_PREFETCH_LIMITS, 32'h0483);
    wr(ADDR_IDLE_XFER_LIMIT, 32'd255);
    wr(ADDR_IDLE_LOWER, 32'd10);
    wr(ADDR_IDLE_UPPER, 32'd24);
    ev(E_FILL);
    wait_disc(24, 28);
    ev(E_FILL);
    repeat (10) @(posedge clk);
    ev(E_HIT);
    wait_disc(24, 28);
    wr(ADDR_IDLE_UPPER, 32'h0fff);
    wr(ADDR_IDLE_LOWER, 32'd40);
    wr(ADDR_IDLE_XFER_LIMIT, 32'd3);
    ev(E_FILL);
    ev(E_CS);
    ev(E_CS);
    ev(E_CS);
    wait_disc(33, 38);
    ev(E_FILL);
    ev(E_CS);
    ev(E_CS);
    d0 = discards;
    repeat (80) @(posedge clk);
    chk("early_discards", d0, discards);
    ev(E_CS);
    wait_disc(0, 4);
    // Global reset restores defaults
    wr(ADDR_IDLE_XFER_LIMIT, 32'h55);
    wr(ADDR_PREFETCH_LIMITS, 32'h0100);
    @(posedge clk);
    global_reset_input_n <= 1'b0;
    repeat (4) @(posedge clk);
    global_reset_input_n <= 1'b1;
    repeat (4) @(posedge clk);
    defaults();
    chk("single_buf_global_reset_input", 32'h0, {31'h0, single_buf});
    test_done();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
